//--- verilog/iem_consts.vh
// constants and contract of the interrupt enable mask block
//
// Contract
// [R1] write to set-low register sets enables of sources 0..31 where data bit is one
// [R2] write to set-high register sets enables of sources 32..63 where data bit is one
// [R3] write to set-base register sets base enables 0..7 where data bit is one
// [R4] write to clear-low register clears enables of sources 0..31 where data is one
// [R5] write to clear-high register clears enables of sources 32..63 where data is one
// [R6] write to clear-base register clears base enables 0..7; bits 31:8 ignored
// [R7] general pending bit is one only when source asserted and enabled
// [R8] base pending bit is one only when base source asserted and enabled
// [R9] no readable view of asserted sources whose enable is clear
// [R10] set and clear registers share one enable store
// [R11] basic pending bit 8: enabled pending source 0..31 other than 7,9,10,18,19
// [R12] basic pending bit 9: enabled pending source 32..63 other than 53..57,62
// [R13] reset clears all enable bits
// [R14] reading set or clear register returns current enables, unused base bits zero
`ifndef IEM_CONSTS_VH
`define IEM_CONSTS_VH

`define IEM_ADDR_W 12
`define IEM_OFF_PEND_BASIC 12'h200
`define IEM_OFF_PEND_LOW 12'h204
`define IEM_OFF_PEND_HIGH 12'h208
`define IEM_OFF_SET_LOW 12'h210
`define IEM_OFF_SET_HIGH 12'h214
`define IEM_OFF_SET_BASE 12'h218
`define IEM_OFF_CLR_LOW 12'h21c
`define IEM_OFF_CLR_HIGH 12'h220
`define IEM_OFF_CLR_BASE 12'h224
`define IEM_OFF_IRQ_STATUS 12'h230
`define IEM_OFF_IRQ_MASK 12'h234

`define IEM_BASE_W 8
`define IEM_RESET_ENABLE 32'h00000000
// sources 0..31 that have a direct basic position: 7,9,10,18,19
`define IEM_DIRECT_LOW 32'h000c0680
// sources 32..63 with direct basic position: 53..57,62 (bits 21..25,30)
`define IEM_DIRECT_HIGH 32'h43e00000

// event status bits
`define IEM_EV_GEN 0
`define IEM_EV_BASE 1
`define IEM_EV_SUMMARY 2
`define IEM_EV_W 3

`endif

//--- verilog/iem_bank.v
// one WIDTH-bit enable bank (32 by default) with write-one-to-set and write-one-to-clear
`timescale 1ns/1ps
module iem_bank #(
  parameter WIDTH = 32
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // strobes and data
  input wire set_stb,
  input wire clr_stb,
  input wire [WIDTH-1:0] wdata,
  // stored enables
  output reg [WIDTH-1:0] enable_q
);
  reg [WIDTH-1:0] enable_d;

  always @* begin
    enable_d = enable_q;
    if (set_stb) begin
      enable_d = enable_d | wdata; // [R1]
    end
    if (clr_stb) begin
      enable_d = enable_d & ~wdata; // [R4]
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_q <= {WIDTH{1'b0}}; // [R13]
    end else begin
      enable_q <= enable_d; // [R10]
    end
  end
endmodule // iem_bank

//--- verilog/iem_top.v
// interrupt enable mask block with apb slave and summary interrupt
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`include "iem_consts.vh"
module iem_top (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`IEM_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // raw interrupt sources, asynchronous to pclk
  input wire [63:0] gen_src,
  input wire [7:0] base_src,
  // summary interrupt
  output reg irq_q
);
  reg [63:0] gen_s1_q;
  reg [63:0] gen_s2_q;
  reg [7:0] base_s1_q;
  reg [7:0] base_s2_q;
  wire [31:0] en_low;
  wire [31:0] en_high;
  wire [31:0] en_base_full;
  wire [7:0] en_base;
  wire [31:0] pend_low;
  wire [31:0] pend_high;
  wire [7:0] pend_base;
  wire sum_low;
  wire sum_high;
  wire [31:0] pend_basic;
  wire acc;
  wire wr;
  wire rd;
  wire commit;
  reg [31:0] rdata_d;
  reg hit_d;
  reg [`IEM_EV_W-1:0] status_q;
  reg [`IEM_EV_W-1:0] status_d;
  reg [`IEM_EV_W-1:0] mask_q;
  reg [`IEM_EV_W-1:0] ev_q;
  wire [`IEM_EV_W-1:0] ev_now;
  wire [`IEM_EV_W-1:0] ev_rise;

  // two-stage sync, first stage only feeds second
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gen_s1_q <= 64'h0;
      gen_s2_q <= 64'h0;
      base_s1_q <= 8'h0;
      base_s2_q <= 8'h0;
    end else begin
      gen_s1_q <= gen_src;
      gen_s2_q <= gen_s1_q;
      base_s1_q <= base_src;
      base_s2_q <= base_s1_q;
    end
  end

  // apb access phase; one wait state
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  // writes land only at the completing edge, so a slow master cannot apply one twice
  assign commit = wr & pready;

  iem_bank #(.WIDTH(32)) u_low (
    .pclk(pclk),
    .presetn(presetn),
    .set_stb(commit && paddr == `IEM_OFF_SET_LOW), // [R1]
    .clr_stb(commit && paddr == `IEM_OFF_CLR_LOW), // [R4]
    .wdata(pwdata),
    .enable_q(en_low)
  );

  iem_bank #(.WIDTH(32)) u_high (
    .pclk(pclk),
    .presetn(presetn),
    .set_stb(commit && paddr == `IEM_OFF_SET_HIGH), // [R2]
    .clr_stb(commit && paddr == `IEM_OFF_CLR_HIGH), // [R5]
    .wdata(pwdata),
    .enable_q(en_high)
  );

  // base bank holds only 8 bits; upper data bits are dropped here and read as zero
  iem_bank #(.WIDTH(`IEM_BASE_W)) u_base (
    .pclk(pclk),
    .presetn(presetn),
    .set_stb(commit && paddr == `IEM_OFF_SET_BASE), // [R3]
    .clr_stb(commit && paddr == `IEM_OFF_CLR_BASE), // [R6]
    .wdata(pwdata[7:0]),
    .enable_q(en_base)
  );
  assign en_base_full = {24'h0, en_base}; // [R14]

  // only enabled sources are ever visible
  assign pend_low = gen_s2_q[31:0] & en_low; // [R7]
  assign pend_high = gen_s2_q[63:32] & en_high; // [R7]
  assign pend_base = base_s2_q & en_base; // [R8]
  assign sum_low = |(pend_low & ~`IEM_DIRECT_LOW); // [R11]
  assign sum_high = |(pend_high & ~`IEM_DIRECT_HIGH); // [R12]
  assign pend_basic = {11'h0, pend_high[30], pend_high[25:21], pend_low[19:18],
    pend_low[10:9], pend_low[7], sum_high, sum_low, pend_base};

  // read mux; raw unmasked sources never reach it
  always @* begin
    rdata_d = 32'h0; // [R9]
    hit_d = 1'b1;
    case (paddr)
      `IEM_OFF_PEND_BASIC: rdata_d = pend_basic;
      `IEM_OFF_PEND_LOW: rdata_d = pend_low;
      `IEM_OFF_PEND_HIGH: rdata_d = pend_high;
      `IEM_OFF_SET_LOW: rdata_d = en_low; // [R14]
      `IEM_OFF_CLR_LOW: rdata_d = en_low; // [R14]
      `IEM_OFF_SET_HIGH: rdata_d = en_high; // [R14]
      `IEM_OFF_CLR_HIGH: rdata_d = en_high; // [R14]
      `IEM_OFF_SET_BASE: rdata_d = en_base_full; // [R14]
      `IEM_OFF_CLR_BASE: rdata_d = en_base_full; // [R14]
      `IEM_OFF_IRQ_STATUS: rdata_d = {29'h0, status_q};
      `IEM_OFF_IRQ_MASK: rdata_d = {29'h0, mask_q};
      default: hit_d = 1'b0;
    endcase
  end

  // registered answer: pready one cycle after the access phase begins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= acc & ~pready;
      pslverr <= acc & ~pready & ~hit_d;
      if (rd && !pready && hit_d) begin
        prdata <= rdata_d;
      end else begin
        prdata <= 32'h0;
      end
    end
  end

  // events: rising edge of any-general, any-base and summary presence
  assign ev_now = {sum_low | sum_high, |pend_base, |pend_low | |pend_high};
  assign ev_rise = ev_now & ~ev_q;

  // the write in the pready cycle commits; set beats clear
  always @* begin
    status_d = status_q;
    if (commit && paddr == `IEM_OFF_IRQ_STATUS) begin
      status_d = status_d & ~pwdata[`IEM_EV_W-1:0];
    end
    status_d = status_d | ev_rise;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_q <= {`IEM_EV_W{1'b0}};
      status_q <= {`IEM_EV_W{1'b0}};
      mask_q <= {`IEM_EV_W{1'b0}};
      irq_q <= 1'b0;
    end else begin
      ev_q <= ev_now;
      status_q <= status_d;
      if (commit && paddr == `IEM_OFF_IRQ_MASK) begin
        mask_q <= pwdata[`IEM_EV_W-1:0];
      end
      irq_q <= |(status_d & mask_q);
    end
  end
endmodule // iem_top

//--- test/iem_props.sv
// apb protocol and readback assertions for the enable mask block
`timescale 1ns/1ps
module iem_props (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave side
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_one_wait: assert property (psel && penable && !pready |=> pready) else $error("late");
  chk_ready_pulse: assert property (pready |=> !pready) else $error("long ready");
  chk_ready_phase: assert property (pready |-> psel && penable) else $error("stray ready");
  chk_err_ready: assert property (pslverr |-> pready) else $error("stray error");
  chk_rdata_idle: assert property (!(pready && !pwrite) |-> prdata == 32'h0) else $error("rdata");
  chk_mapped_ok: assert property (pready && paddr == 12'h210 |-> !pslverr) else $error("err");
  chk_base_upper: assert property (pready && !pwrite && (paddr == 12'h218 ||
    paddr == 12'h224) |-> prdata[31:8] == 24'h0) else $error("base upper");
  chk_basic_upper: assert property (pready && !pwrite && paddr == 12'h200
    |-> prdata[31:21] == 11'h0) else $error("basic upper");
endmodule // iem_props
bind iem_top iem_props i_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
  .pready, .pslverr);

//--- test/tb_top.sv
// self-checking apb testbench for the enable mask block
`timescale 1ns/1ps
module tb_top;
  reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
  reg [11:0] paddr = 12'h0;
  reg [31:0] pwdata = 32'h0, r;
  // sources held high so only the enables decide what is visible
  reg [63:0] gen_src = 64'hffffffffffffffff;
  reg [7:0] base_src = 8'hff;
  wire [31:0] prdata;
  wire pready, pslverr, irq_q;
  integer n_mismatch = 0, n_compared = 0, cyc = 0, i;
  iem_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .gen_src, .base_src, .irq_q);
  always #4 pclk = ~pclk;
  task end_sim;
    if (n_mismatch == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      n_mismatch = n_mismatch + 1;
      end_sim;
    end
  end
  task chk(input [31:0] seen, input [31:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // an idle edge after release keeps psel from being assigned twice in one step
  task wr(input [11:0] a, input w, input [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rd(input [11:0] a, input [31:0] exp);
    wr(a, 1'b0, 32'h0);
    chk(r, exp);
  endtask
  task irq_is(input v);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq_q}, {31'h0, v});
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (i = 0; i < 6; i = i + 1)
      rd(12'(12'h210 + 4 * i), 32'h0);
    rd(12'h204, 32'h0);
    rd(12'h200, 32'h0);
    wr(12'h210, 1'b1, 32'hf0);
    wr(12'h210, 1'b1, 32'hf00);
    rd(12'h21c, 32'hff0);
    rd(12'h204, 32'hff0);
    rd(12'h200, 32'h1d00);
    wr(12'h21c, 1'b1, 32'hf0);
    rd(12'h210, 32'hf00);
    rd(12'h200, 32'h1900);
    wr(12'h21c, 1'b1, 32'hffffffff);
    wr(12'h210, 1'b1, 32'h80);
    rd(12'h200, 32'h400);
    wr(12'h214, 1'b1, 32'h43e00000);
    rd(12'h200, 32'h1f8400);
    wr(12'h214, 1'b1, 32'h1);
    rd(12'h208, 32'h43e00001);
    rd(12'h200, 32'h1f8600);
    wr(12'h220, 1'b1, 32'hffffffff);
    rd(12'h214, 32'h0);
    wr(12'h218, 1'b1, 32'hffffffff);
    rd(12'h218, 32'hff);
    wr(12'h224, 1'b1, 32'hffffff0f);
    rd(12'h224, 32'hf0);
    rd(12'h200, 32'h4f0);
    rd(12'h230, 32'h7);
    wr(12'h234, 1'b1, 32'h2);
    irq_is(1'b1);
    wr(12'h230, 1'b1, 32'h2);
    irq_is(1'b0);
    rd(12'h230, 32'h5);
    rd(12'h000, 32'h0);
    chk({31'h0, e}, 32'h1);
    end_sim;
  end
endmodule // tb_top
